// >>> core/dfs_pkg.sv
// dfs_pkg.sv: constants and types of the data-flash command sequencer
// How it works
// - Software loads the parameters and then clears the complete flag, which launches the command.
// - Supplied words go to the array and are programmed only when the target area is unprotected.
// - The parameter index at launch sets the word count, and index 101 holds the fourth word.
// - A program launch with index below 010 or above 101 sets the access error flag.
// - A launch that the current operating mode does not permit sets the access error flag.
// - A 23-bit global address outside the data-flash sets the access error flag.
// - A program address with bit 0 set is misaligned and sets the access error flag.
// - A run of words that passes the end of the data-flash sets the access error flag.
// - A protected target sets the protection violation flag and nothing is programmed.
// - Any mismatch found while verifying sets the verify error flag.
// - A mismatch that cannot be corrected sets the verify uncorrectable flag.
// - The complete flag sets again when a program command has finished.
// - Sector erase sets every word of the one sector that holds the supplied address to all ones.
// - After an erase launch the sector is erased and then read back as erased.
// - The complete flag sets once erase and its read-back have finished.
package dfs_pkg;
    // register byte offsets
    localparam logic [4:0] OFF_STATUS = 5'h00;
    localparam logic [4:0] OFF_INDEX = 5'h04;
    localparam logic [4:0] OFF_DATA = 5'h08;
    localparam logic [4:0] OFF_IRQ_STS = 5'h0C;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
    localparam logic [4:0] OFF_PROTECT = 5'h14;
    // flash_status_register bit positions
    localparam int ST_COMPLETE = 7;
    localparam int ST_ACC = 5;
    localparam int ST_PROT = 4;
    localparam int ST_VERR = 1;
    localparam int ST_VUNC = 0;
    // interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ACC = 1;
    localparam int IRQ_PROT = 2;
    localparam int IRQ_VERR = 3;
    localparam int IRQ_W = 4;
    // reset values
    localparam logic [IRQ_W-1:0] IRQ_STS_RST = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [7:0] PROTECT_RST = 8'h00;
    localparam logic [2:0] INDEX_RST = 3'h0;
    // command codes and index limits
    localparam logic [7:0] ERASE_CODE = 8'h12;
    localparam logic [2:0] IDX_MIN = 3'h2;
    localparam logic [2:0] IDX_MAX = 3'h5;
    localparam logic [2:0] IDX_ERASE = 3'h1;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    // timing: least times, rounded up to whole cycles
    localparam int CLK_NS = 4;
    localparam int PROG_WORD_NS = 40;
    localparam int ERASE_NS = 400;
    localparam int PROG_CYC = (PROG_WORD_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 16;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CHECK = 7'h02,
        ST_WRITE = 7'h04,
        ST_WAIT = 7'h08,
        ST_READ = 7'h10,
        ST_CMP = 7'h20,
        ST_DONE = 7'h40
    } dfs_state_t;

    // command captured at launch
    typedef struct packed {
        logic [7:0] code;
        logic [22:0] gaddr;
        logic [2:0] idx;
    } dfs_cmd_t;

    // status flags
    typedef struct packed {
        logic command_complete_flag;
        logic access_error_flag;
        logic protection_violation_flag;
        logic verify_error_flag;
        logic verify_uncorrectable_flag;
    } dfs_flags_t;
endpackage

// >>> core/dfs_array.sv
// dfs_array.sv: data-flash word array with program and erase write port
`timescale 1ns/1ps
module dfs_array #(
    parameter int WORDS = 16384,
    parameter int AW = 14
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic wen,
    input wire logic erase,
    input wire logic [AW-1:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [15:0] rdata
);
    logic [15:0] mem [0:WORDS-1];

    // program only clears bits, erase sets the whole word
    always_ff @(posedge clk)
    begin
        if (ce && wen)
        begin
            if (erase)
                mem[waddr] <= dfs_pkg::ERASED_WORD;
            else
                mem[waddr] <= mem[waddr] & wdata;
        end
    end

    // registered read port
    always_ff @(posedge clk)
    begin
        if (ce)
            rdata <= mem[raddr];
    end
endmodule // dfs_array

// >>> core/dfs_sequencer.sv
// dfs_sequencer.sv: data-flash program and erase command sequencer
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dfs_sequencer #(
    parameter int DF_WORDS = 16384,
    parameter int AW = 14,
    parameter int SECT_WORDS = 128,
    parameter int SECT_SH = 7,
    parameter logic [22:0] DF_BASE = 23'h100000,
    parameter logic [7:0] PROG_CODE = 8'h11
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic cmd_mode_permit
);
    localparam logic [23:0] DF_BYTES = 24'(2 * DF_WORDS);
    localparam logic [AW-1:0] SECT_MASK = AW'(SECT_WORDS - 1);

    dfs_pkg::dfs_state_t st_reg;
    dfs_pkg::dfs_cmd_t cmd_reg;
    dfs_pkg::dfs_flags_t flags_reg;
    logic [15:0] param_array_reg [0:7];
    logic [2:0] command_param_index_reg;
    logic [dfs_pkg::IRQ_W-1:0] irq_sts_reg;
    logic [dfs_pkg::IRQ_W-1:0] irq_sts_next;
    logic [dfs_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [7:0] protect_reg;
    logic [AW-1:0] ptr_reg;
    logic [AW-1:0] first_reg;
    logic [AW-1:0] last_reg;
    logic is_erase_reg;
    logic [dfs_pkg::TMR_W-1:0] timer_reg;
    logic [31:0] readdata_reg;
    logic waitreq_reg;
    logic irq_reg;
    logic [15:0] rdata;

    // address decode shared by read and write paths
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    // more than one differing bit cannot be corrected
    function automatic logic multi_bit(input logic [15:0] x);
        multi_bit = (x & (x - 16'h0001)) != 16'h0000;
    endfunction

    // bus handshake qualifiers
    logic bus_go;
    logic wr_go;
    logic rd_go;
    logic wr_lo;
    assign bus_go = ce && (avs_read || avs_write) && waitreq_reg;
    // writes land on the answer edge, when waitrequest is low
    assign wr_go = ce && avs_write && !waitreq_reg;
    assign rd_go = bus_go && avs_read && !avs_write;
    assign wr_lo = wr_go && avs_byteenable[0];

    logic launch;
    assign launch = wr_lo && hit(avs_address, dfs_pkg::OFF_STATUS)
        && avs_writedata[dfs_pkg::ST_COMPLETE]
        && flags_reg.command_complete_flag
        && !flags_reg.access_error_flag
        && !flags_reg.protection_violation_flag;

    // launch checks on the captured command
    logic [22:0] off;
    logic in_range;
    logic [2:0] nw;
    logic [23:0] span_end;
    logic [AW-1:0] word;
    logic is_prog;
    logic is_ers;
    logic prot_hit;
    logic bad_idx;
    logic acc_any;
    logic check_fail;
    assign off = cmd_reg.gaddr - DF_BASE;
    assign is_prog = (cmd_reg.code == PROG_CODE);
    assign is_ers = (cmd_reg.code == dfs_pkg::ERASE_CODE);
    assign nw = cmd_reg.idx - 3'h1;
    assign span_end = {1'b0, off} + {20'h00000, nw, 1'b0};
    assign word = off[AW:1];
    assign in_range = (cmd_reg.gaddr >= DF_BASE) && ({1'b0, off} < DF_BYTES);
    assign bad_idx = is_prog
        ? (cmd_reg.idx < dfs_pkg::IDX_MIN || cmd_reg.idx > dfs_pkg::IDX_MAX)
        : (cmd_reg.idx != dfs_pkg::IDX_ERASE);
    assign acc_any = !cmd_mode_permit || !(is_prog || is_ers) || !in_range
        || bad_idx || (is_prog && (cmd_reg.gaddr[0] || span_end > DF_BYTES));
    assign prot_hit = in_range && ((word >> SECT_SH) < AW'(protect_reg));
    assign check_fail = (st_reg == dfs_pkg::ST_CHECK) && (acc_any || prot_hit);

    // verify compare
    logic [15:0] exp_word;
    logic [2:0] widx;
    logic [15:0] diff;
    logic mismatch;
    assign widx = 3'(ptr_reg - first_reg);
    assign exp_word = is_erase_reg ? dfs_pkg::ERASED_WORD
        : param_array_reg[3'(dfs_pkg::IDX_MIN + widx)];
    assign diff = rdata ^ exp_word;
    assign mismatch = (st_reg == dfs_pkg::ST_CMP) && (diff != 16'h0000);

    // array write strobe only in the write phase
    logic arr_wen;
    assign arr_wen = (st_reg == dfs_pkg::ST_WRITE);

    dfs_array #(
        .WORDS(DF_WORDS),
        .AW(AW)
    ) u_array (
        .clk(clk),
        .ce(ce),
        .wen(arr_wen),
        .erase(is_erase_reg),
        .waddr(ptr_reg),
        .wdata(exp_word),
        .raddr(ptr_reg),
        .rdata(rdata)
    );

    // sequencer state machine
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= dfs_pkg::ST_IDLE;
            cmd_reg <= '0;
            ptr_reg <= '0;
            first_reg <= '0;
            last_reg <= '0;
            is_erase_reg <= 1'b0;
            timer_reg <= '0;
        end
        else if (ce)
        begin
            unique case (st_reg)
                dfs_pkg::ST_IDLE:
                begin
                    if (launch)
                    begin
                        cmd_reg.code <= param_array_reg[0][15:8];
                        cmd_reg.gaddr <= {param_array_reg[0][6:0],
                            param_array_reg[1]};
                        cmd_reg.idx <= command_param_index_reg;
                        st_reg <= dfs_pkg::ST_CHECK;
                    end
                end
                dfs_pkg::ST_CHECK:
                begin
                    if (acc_any || prot_hit)
                        st_reg <= dfs_pkg::ST_IDLE;
                    else if (is_ers)
                    begin
                        is_erase_reg <= 1'b1;
                        ptr_reg <= word & ~SECT_MASK;
                        first_reg <= word & ~SECT_MASK;
                        last_reg <= word | SECT_MASK;
                        st_reg <= dfs_pkg::ST_WRITE;
                    end
                    else
                    begin
                        is_erase_reg <= 1'b0;
                        ptr_reg <= word;
                        first_reg <= word;
                        last_reg <= word + AW'(nw) - AW'(1);
                        st_reg <= dfs_pkg::ST_WRITE;
                    end
                end
                dfs_pkg::ST_WRITE:
                begin
                    // erase every word, then wait and verify
                    if (is_erase_reg && ptr_reg != last_reg)
                        ptr_reg <= ptr_reg + AW'(1);
                    else if (is_erase_reg)
                    begin
                        ptr_reg <= first_reg;
                        timer_reg <= dfs_pkg::TMR_W'(dfs_pkg::ERASE_CYC);
                        st_reg <= dfs_pkg::ST_WAIT;
                    end
                    else
                    begin
                        timer_reg <= dfs_pkg::TMR_W'(dfs_pkg::PROG_CYC);
                        st_reg <= dfs_pkg::ST_WAIT;
                    end
                end
                dfs_pkg::ST_WAIT:
                begin
                    if (timer_reg <= dfs_pkg::TMR_W'(1))
                        st_reg <= dfs_pkg::ST_READ;
                    else
                        timer_reg <= timer_reg - dfs_pkg::TMR_W'(1);
                end
                dfs_pkg::ST_READ:
                    st_reg <= dfs_pkg::ST_CMP;
                dfs_pkg::ST_CMP:
                begin
                    if (ptr_reg == last_reg)
                        st_reg <= dfs_pkg::ST_DONE;
                    else if (is_erase_reg)
                    begin
                        ptr_reg <= ptr_reg + AW'(1);
                        st_reg <= dfs_pkg::ST_READ;
                    end
                    else
                    begin
                        ptr_reg <= ptr_reg + AW'(1);
                        st_reg <= dfs_pkg::ST_WRITE;
                    end
                end
                dfs_pkg::ST_DONE:
                    st_reg <= dfs_pkg::ST_IDLE;
            endcase
        end
    end

    // status flags, hardware set wins over software clear
    always_ff @(posedge clk)
    begin
        if (rst)
            flags_reg <= 5'b10000;
        else if (ce)
        begin
            if (launch)
                flags_reg.command_complete_flag <= 1'b0;
            else if (st_reg == dfs_pkg::ST_DONE || check_fail)
                flags_reg.command_complete_flag <= 1'b1;
            if (check_fail && acc_any)
                flags_reg.access_error_flag <= 1'b1;
            else if (wr_lo && hit(avs_address, dfs_pkg::OFF_STATUS)
                && avs_writedata[dfs_pkg::ST_ACC])
                flags_reg.access_error_flag <= 1'b0;
            if (check_fail && prot_hit)
                flags_reg.protection_violation_flag <= 1'b1;
            else if (wr_lo && hit(avs_address, dfs_pkg::OFF_STATUS)
                && avs_writedata[dfs_pkg::ST_PROT])
                flags_reg.protection_violation_flag <= 1'b0;
            if (mismatch)
                flags_reg.verify_error_flag <= 1'b1;
            else if (launch)
                flags_reg.verify_error_flag <= 1'b0;
            if (mismatch && multi_bit(diff))
                flags_reg.verify_uncorrectable_flag <= 1'b1;
            else if (launch)
                flags_reg.verify_uncorrectable_flag <= 1'b0;
        end
    end

    // parameter index, array and protection, writable while idle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            command_param_index_reg <= dfs_pkg::INDEX_RST;
            protect_reg <= dfs_pkg::PROTECT_RST;
        end
        else if (ce && flags_reg.command_complete_flag)
        begin
            if (wr_lo && hit(avs_address, dfs_pkg::OFF_INDEX))
                command_param_index_reg <= avs_writedata[2:0];
            if (wr_lo && hit(avs_address, dfs_pkg::OFF_PROTECT))
                protect_reg <= avs_writedata[7:0];
            if (wr_go && hit(avs_address, dfs_pkg::OFF_DATA))
            begin
                if (avs_byteenable[0])
                    param_array_reg[command_param_index_reg][7:0]
                        <= avs_writedata[7:0];
                if (avs_byteenable[1])
                    param_array_reg[command_param_index_reg][15:8]
                        <= avs_writedata[15:8];
            end
        end
    end

    // interrupt event collection
    always_comb
    begin
        irq_sts_next = irq_sts_reg;
        if (wr_lo && hit(avs_address, dfs_pkg::OFF_IRQ_STS))
            irq_sts_next = irq_sts_next & ~avs_writedata[dfs_pkg::IRQ_W-1:0];
        if (st_reg == dfs_pkg::ST_DONE || check_fail)
            irq_sts_next[dfs_pkg::IRQ_DONE] = 1'b1;
        if (check_fail && acc_any)
            irq_sts_next[dfs_pkg::IRQ_ACC] = 1'b1;
        if (check_fail && prot_hit)
            irq_sts_next[dfs_pkg::IRQ_PROT] = 1'b1;
        if (mismatch)
            irq_sts_next[dfs_pkg::IRQ_VERR] = 1'b1;
    end

    // interrupt status, mask and output
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_sts_reg <= dfs_pkg::IRQ_STS_RST;
            irq_mask_reg <= dfs_pkg::IRQ_MASK_RST;
            irq_reg <= 1'b0;
        end
        else if (ce)
        begin
            irq_sts_reg <= irq_sts_next;
            if (wr_lo && hit(avs_address, dfs_pkg::OFF_IRQ_MASK))
                irq_mask_reg <= avs_writedata[dfs_pkg::IRQ_W-1:0];
            irq_reg <= |(irq_sts_next & irq_mask_reg);
        end
    end

    // read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h00000000;
        if (hit(avs_address, dfs_pkg::OFF_STATUS))
        begin
            rd_mux[dfs_pkg::ST_COMPLETE] = flags_reg.command_complete_flag;
            rd_mux[dfs_pkg::ST_ACC] = flags_reg.access_error_flag;
            rd_mux[dfs_pkg::ST_PROT] = flags_reg.protection_violation_flag;
            rd_mux[dfs_pkg::ST_VERR] = flags_reg.verify_error_flag;
            rd_mux[dfs_pkg::ST_VUNC] = flags_reg.verify_uncorrectable_flag;
        end
        else if (hit(avs_address, dfs_pkg::OFF_INDEX))
            rd_mux[2:0] = command_param_index_reg;
        else if (hit(avs_address, dfs_pkg::OFF_DATA))
            rd_mux[15:0] = param_array_reg[command_param_index_reg];
        else if (hit(avs_address, dfs_pkg::OFF_IRQ_STS))
            rd_mux[dfs_pkg::IRQ_W-1:0] = irq_sts_reg;
        else if (hit(avs_address, dfs_pkg::OFF_IRQ_MASK))
            rd_mux[dfs_pkg::IRQ_W-1:0] = irq_mask_reg;
        else if (hit(avs_address, dfs_pkg::OFF_PROTECT))
            rd_mux[7:0] = protect_reg;
    end

    // one wait cycle, then a one-cycle answer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            waitreq_reg <= 1'b1;
            readdata_reg <= 32'h00000000;
        end
        else if (ce)
        begin
            if (!waitreq_reg)
                waitreq_reg <= 1'b1;
            else if (avs_read || avs_write)
                waitreq_reg <= 1'b0;
            if (rd_go)
                readdata_reg <= rd_mux;
        end
    end

    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = waitreq_reg;
    assign irq = irq_reg;

    chk_launch_clears: assert property (@(posedge clk) disable iff (rst)
        launch |=> !flags_reg.command_complete_flag
            && st_reg == dfs_pkg::ST_CHECK)
        else $error("launch did not start a command");

    chk_index_bounds: assert property (@(posedge clk) disable iff (rst)
        (ce && st_reg == dfs_pkg::ST_CHECK && is_prog
            && (cmd_reg.idx < 3'h2 || cmd_reg.idx > 3'h5))
        |=> flags_reg.access_error_flag)
        else $error("bad index left access error clear");

    chk_mode_block: assert property (@(posedge clk) disable iff (rst)
        (ce && st_reg == dfs_pkg::ST_CHECK && !cmd_mode_permit)
        |=> flags_reg.access_error_flag && st_reg == dfs_pkg::ST_IDLE)
        else $error("forbidden mode not refused");

    chk_misaligned: assert property (@(posedge clk) disable iff (rst)
        (ce && st_reg == dfs_pkg::ST_CHECK && is_prog && cmd_reg.gaddr[0])
        |=> flags_reg.access_error_flag)
        else $error("odd address accepted");

    chk_range_end: assert property (@(posedge clk) disable iff (rst)
        (ce && st_reg == dfs_pkg::ST_CHECK && is_prog
            && span_end > DF_BYTES)
        |=> flags_reg.access_error_flag)
        else $error("run past block end accepted");

    chk_protect_hold: assert property (@(posedge clk) disable iff (rst)
        (ce && st_reg == dfs_pkg::ST_CHECK && prot_hit)
        |=> flags_reg.protection_violation_flag ##0 !arr_wen [*4])
        else $error("protected area written or flag missing");

    chk_fail_done: assert property (@(posedge clk) disable iff (rst)
        (ce && check_fail) |=> flags_reg.command_complete_flag
            && st_reg == dfs_pkg::ST_IDLE)
        else $error("failed launch not completed at once");

    chk_write_phase: assert property (@(posedge clk) disable iff (rst)
        arr_wen |-> $past(st_reg) != dfs_pkg::ST_IDLE
            && !flags_reg.command_complete_flag)
        else $error("array written outside an operation");

    chk_verify_err: assert property (@(posedge clk) disable iff (rst)
        (ce && mismatch) |=> flags_reg.verify_error_flag)
        else $error("verify mismatch not flagged");

    chk_verify_unc: assert property (@(posedge clk) disable iff (rst)
        (ce && mismatch && multi_bit(diff))
        |=> flags_reg.verify_uncorrectable_flag)
        else $error("multi-bit mismatch not flagged");

    chk_done_sets: assert property (@(posedge clk) disable iff (rst)
        (ce && st_reg == dfs_pkg::ST_DONE)
        |=> flags_reg.command_complete_flag)
        else $error("complete flag not set at end");
endmodule // dfs_sequencer

// >>> sim/dfs_mode_model.sv
// dfs_mode_model.sv: operating-mode source that grants or bars commands
`timescale 1ns/1ps
module dfs_mode_model (
    input wire logic clk,
    input wire logic want_permit,
    output logic cmd_mode_permit
);
    // mode grant
    // mode changes land one edge after the bench asks
    always_ff @(posedge clk)
    begin
        cmd_mode_permit <= want_permit;
    end
endmodule // dfs_mode_model

// >>> sim/dfs_sequencer_tb_top.sv
// dfs_sequencer_tb_top.sv: self-checking bench of the command sequencer
`timescale 1ns/1ps
module dfs_sequencer_tb_top;
    localparam logic [22:0] BASE = 23'h100000;
    localparam logic [7:0] PRG = 8'h11;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, irq, cmd_mode_permit, pm;
    logic want_permit = 1'b1;
    logic [22:0] ga;
    logic [2:0] ix;
    int miscompares = 0;
    int n_checks = 0;
    int seed = 32'h36718c94;
    int i;
    dfs_sequencer DUT (.clk(clk), .rst(rst), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq),
        .cmd_mode_permit(cmd_mode_permit));
    dfs_mode_model mode_src (.clk(clk), .want_permit(want_permit),
        .cmd_mode_permit(cmd_mode_permit));
    // free-running 4 ns clock
    initial
    begin
        forever #2 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // one transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input int d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100)
        begin
            miscompares++;
            print_verdict();
        end
    endtask
    // load parameters, launch, poll the complete flag
    task automatic cmd(input logic [7:0] c, input logic [22:0] a,
        input logic [2:0] x, input logic [15:0] w);
        int k;
        bus(1, dfs_pkg::OFF_INDEX, 0);
        bus(1, dfs_pkg::OFF_DATA, {16'h0, c, 1'b0, a[22:16]});
        bus(1, dfs_pkg::OFF_INDEX, 1);
        bus(1, dfs_pkg::OFF_DATA, {16'h0, a[15:0]});
        for (k = 2; k < 6; k++)
        begin
            bus(1, dfs_pkg::OFF_INDEX, k);
            bus(1, dfs_pkg::OFF_DATA, {16'h0, w});
        end
        bus(1, dfs_pkg::OFF_INDEX, {29'h0, x});
        bus(1, dfs_pkg::OFF_STATUS, 32'h80);
        k = 0;
        do
        begin
            bus(0, dfs_pkg::OFF_STATUS, 0);
            k++;
        end
        while (rd[7] !== 1'b1 && k < 400);
        if (k >= 400)
        begin
            miscompares++;
            print_verdict();
        end
    endtask
    // expected status of a program launch
    function automatic logic [31:0] exp_st(input logic [22:0] a,
        input logic [2:0] x, input logic p, input int prot);
        int off;
        logic acc, inr;
        off = int'(a) - int'(BASE);
        inr = off >= 0 && off < 32'h8000;
        acc = x < 3'h2 || x > 3'h5 || !p || a[0] || !inr;
        acc = acc || off + 2 * (int'(x) - 2) > 32'h7FFE;
        return {24'h0, 2'b10, acc, inr && (off >> 8) < prot, 4'h0};
    endfunction
    // reset, then every scenario in turn
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, dfs_pkg::OFF_STATUS, 0);
        chk(rd, 32'h80);
        cmd(8'h12, BASE, 3'h1, 16'h0);
        chk(rd, 32'h80);
        cmd(8'h12, BASE + 23'h17E, 3'h1, 16'h0);
        chk(rd, 32'h80);
        ix = 3'h2 + 3'($unsigned($random(seed)) % 4);
        cmd(PRG, BASE + 23'h10, ix, 16'($random(seed)));
        chk(rd, exp_st(BASE + 23'h10, ix, 1'b1, 0));
        cmd(PRG, BASE + 23'h40, 3'h2, 16'h0000);
        cmd(PRG, BASE + 23'h40, 3'h2, 16'hFFFF);
        chk(rd, 32'h83);
        cmd(PRG, BASE + 23'h60, 3'h2, 16'hFFFE);
        cmd(PRG, BASE + 23'h60, 3'h2, 16'hFFFF);
        chk(rd, 32'h82);
        cmd(8'h12, BASE, 3'h1, 16'h0);
        chk(rd, 32'h80);
        $display("test erase and program done");
        bus(1, dfs_pkg::OFF_PROTECT, 1);
        cmd(PRG, BASE + 23'h20, 3'h2, 16'h0000);
        chk(rd, exp_st(BASE + 23'h20, 3'h2, 1'b1, 1));
        chk_bit(irq, 1'b0);
        bus(1, dfs_pkg::OFF_IRQ_MASK, 32'hF);
        bus(0, dfs_pkg::OFF_IRQ_STS, 0);
        chk_bit(irq, 1'b1);
        chk(rd & 32'h4, 32'h4);
        bus(1, dfs_pkg::OFF_IRQ_STS, 32'hF);
        bus(1, dfs_pkg::OFF_STATUS, 32'h30);
        bus(1, dfs_pkg::OFF_PROTECT, 0);
        chk_bit(irq, 1'b0);
        cmd(PRG, BASE + 23'h20, 3'h2, 16'hFFFF);
        chk(rd, 32'h80);
        $display("test protection and interrupt done");
        // fixed corner cases first, then random launches
        for (i = 0; i < 14; i++)
        begin
            ga = BASE + 23'h100 + 23'($unsigned($random(seed)) % 248);
            ix = 3'($random(seed));
            pm = 1'($random(seed));
            case (i)
                0: {ga, ix, pm} = {BASE, 3'h1, 1'b1};
                1: {ga, ix, pm} = {BASE, 3'h6, 1'b1};
                2: {ga, ix, pm} = {BASE + 23'h3, 3'h2, 1'b1};
                3: {ga, ix, pm} = {BASE - 23'h2, 3'h2, 1'b1};
                4: {ga, ix, pm} = {BASE + 23'h7FFE, 3'h3, 1'b1};
                5: {ga, ix, pm} = {BASE, 3'h2, 1'b0};
                default: ;
            endcase
            want_permit <= pm;
            cmd(PRG, ga, ix, 16'hFFFF);
            chk(rd, exp_st(ga, ix, pm, 0));
            bus(1, dfs_pkg::OFF_STATUS, 32'h30);
        end
        $display("test launch checks done");
        print_verdict();
    end
endmodule // dfs_sequencer_tb_top
